// [ass_pkg.sv]
// Constants, types and state codes for the amplifier supply sequencer.
//
// Operation
// - Step mains-on, available, auxiliaries, high tension in order.
// - Gates are satisfied strictly one after another.
// - Lamps lit up to the failed step only.
// - Auxiliaries complete needs four inputs, one delayed.
// - Free-running 16 Hz tick feeds a divider.
// - Filament off clears divider, latches, output high.
// - Count latch sets 48 s after counting starts.
// - Delay complete output goes low two seconds later.
// - Both latches hold until filament input falls.
// - Low pulse on restoration resets both latches.
// - Outage under one second skips count, two-second reheat.
// - Outage over one second runs the full count.
// - Switch-off resets latches, memory lapses after one second.
// - Main contactor off releases step-start, clears timer.
`default_nettype none
package ass_pkg;
    // *************************************************************
    // Timing constants.
    // *************************************************************
    localparam int CLK_HZ        = 10_000_000; // System clock rate.
    localparam int TICK_HZ       = 16;         // Oscillator repetition rate.
    localparam int TICK_CYCLES   = CLK_HZ / TICK_HZ; // Clocks per tick.
    localparam int FIL_DELAY_S   = 48;         // Full filament delay.
    localparam int REHEAT_S      = 2;          // Reheat after the count latch.
    localparam int OUTAGE_S      = 1;          // Outage memory lifetime.
    localparam int STEP_START_MS = 100;        // Step-start delay.
    localparam int STEP_CYCLES   = (CLK_HZ / 1000) * STEP_START_MS;
    localparam logic [9:0] FIL_TICKS    = 10'(FIL_DELAY_S * TICK_HZ);
    localparam logic [9:0] REHEAT_TICKS = 10'(REHEAT_S * TICK_HZ);
    localparam logic [9:0] OUTAGE_TICKS = 10'(OUTAGE_S * TICK_HZ);
    localparam int N_GATES = 8; // Number of sequence gates and lamps.

    // *************************************************************
    // Sequence states, one per satisfied gate.
    // *************************************************************
    typedef enum logic [3:0] {
        SEQ_OFF, SEQ_MAINS_ON, SEQ_AVAILABLE, SEQ_AUX_START, SEQ_FIL_START,
        SEQ_AUX_COMPLETE, SEQ_HT_START, SEQ_SCREEN_START, SEQ_STANDBY
    } ass_seq_e;

    // Status and contactor inputs from the amplifier.
    typedef struct packed {
        logic mains_on;              // Mains present, high.
        logic supplies_normal_input; // Control supplies normal, high.
        logic aux_select;            // Auxiliaries selected by the switch.
        logic fil_bias_aux_started;  // Filament, bias, aux supplies started.
        logic fil_supply_ok;         // Filament supply healthy.
        logic bias_ok;               // Bias supply healthy.
        logic aux_supply_ok;         // Auxiliary supplies healthy.
        logic ht_select;             // High tension selected by the switch.
        logic main_contactor_input;  // Main contactor, low when energised.
        logic screen_ok;             // Final stage screen supply up.
        logic tune_complete;         // Auto-tune complete.
        logic filament_on_input;     // Filament supply on, high.
    } ass_in_s;

    // Commands and lamps toward the amplifier and metering panel.
    typedef struct packed {
        logic [N_GATES-1:0] lamps;     // Step lamps, bit 0 is mains on.
        logic fil_bias_start_cmd;      // Start filament, bias, aux supplies.
        logic ht_start_cmd;            // Start high tension.
        logic screen_start_cmd;        // Start final stage screen supply.
        logic filament_delay_complete_n; // Delay complete, active low.
        logic filament_delay_indicator;  // Delay lamp, lit high.
        logic step_start_contactor_n;    // Step-start contactor, active low.
    } ass_out_s;

    // Reset value of the output group: all off, active-low lines high.
    localparam ass_out_s OUT_RESET = '{lamps: '0, fil_bias_start_cmd: 1'b0,
        ht_start_cmd: 1'b0, screen_start_cmd: 1'b0,
        filament_delay_complete_n: 1'b1, filament_delay_indicator: 1'b0,
        step_start_contactor_n: 1'b1};

    // Idle input levels: the main contactor line rests high, de-energised,
    // so a reset never looks like a closed contactor.
    localparam ass_in_s IN_RESET = '{main_contactor_input: 1'b1, default: 1'b0};

    // Thermometer lamp pattern for a sequence state.
    function automatic logic [N_GATES-1:0] lamp_bar(input ass_seq_e s);
        logic [N_GATES:0] one;
        one = '0;
        one[int'(s)] = 1'b1;
        return N_GATES'(one - 1'b1);
    endfunction
endpackage
`default_nettype wire

// [ass_sequencer.sv]
// Amplifier supply sequencer: gate chain, filament delay and step-start.
`timescale 1ns/1ps
`default_nettype none
module ass_sequencer #(
    parameter int TICK_CYC = ass_pkg::TICK_CYCLES, // Clocks per 16 Hz tick.
    parameter int STEP_CYC = ass_pkg::STEP_CYCLES, // Step-start delay clocks.
    parameter int FILT_CYC = ass_pkg::TICK_CYCLES  // Glitch filter length.
) (
    input  wire logic           clk,
    input  wire logic           resetn,
    input  wire ass_pkg::ass_in_s  amp_in,
    output var  ass_pkg::ass_out_s amp_out
);
    import ass_pkg::*;

    localparam int NI = $bits(ass_in_s);            // Input count.
    localparam int TW = $clog2(TICK_CYC + 1);       // Tick counter width.
    localparam int SW = $clog2(STEP_CYC + 1);       // Step counter width.
    localparam int FW = $clog2(FILT_CYC + 1);       // Filter counter width.
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);
    localparam logic [SW-1:0] STEP_LAST = SW'(STEP_CYC - 1);
    localparam logic [FW-1:0] FILT_LAST = FW'(FILT_CYC - 1);

    // *************************************************************
    // Reset release.
    // *************************************************************
    logic [1:0] rst_sync_reg; // Release shifter; bit 1 is the used reset.
    logic       rst_n;        // Synchronised active-low reset.

    // Assert asynchronously, release on the second clock edge.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // *************************************************************
    // Input synchroniser and glitch filter.
    // *************************************************************
    logic [NI-1:0] sync1_reg;                // First stage, read only by stage two.
    logic [NI-1:0] sync2_reg;                // Second stage.
    logic [NI-1:0] filt_reg, filt_next;      // Accepted input levels.
    logic [FW-1:0] fcnt_reg [NI];            // Per-input stability counters.
    logic [FW-1:0] fcnt_next [NI];
    ass_in_s       din;                      // Filtered inputs as a struct.

    // A new level is accepted only after standing a full filter period,
    // so a contact bounce never steps the sequence.
    always_comb begin
        filt_next = filt_reg;
        for (int i = 0; i < NI; i++) begin
            fcnt_next[i] = '0;
            if (sync2_reg[i] != filt_reg[i]) begin
                if (fcnt_reg[i] == FILT_LAST) begin
                    filt_next[i] = sync2_reg[i];
                end else begin
                    fcnt_next[i] = fcnt_reg[i] + 1'b1;
                end
            end
        end
    end

    // Registers of the input path.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= IN_RESET;
            sync2_reg <= IN_RESET;
            filt_reg  <= IN_RESET;
            for (int i = 0; i < NI; i++) begin
                fcnt_reg[i] <= '0;
            end
        end else begin
            sync1_reg <= amp_in;
            sync2_reg <= sync1_reg;
            filt_reg  <= filt_next;
            fcnt_reg  <= fcnt_next;
        end
    end
    assign din = ass_in_s'(filt_reg);

    // *************************************************************
    // Free-running 16 Hz tick.
    // *************************************************************
    logic [TW-1:0] tcnt_reg, tcnt_next; // Clocks within the tick.
    logic          tick;                // One-cycle tick strobe.

    // The oscillator never stops, so the filament, reheat and outage delays share one time base.
    always_comb begin
        tick      = (tcnt_reg == TICK_LAST);
        tcnt_next = tick ? '0 : tcnt_reg + 1'b1;
    end

    // *************************************************************
    // Filament delay and mains-fail override.
    // *************************************************************
    logic       fil_on;                    // Filament supply on.
    logic [9:0] div_reg, div_next;         // Tick divider.
    logic [9:0] reheat_reg, reheat_next;   // Ticks since the count latch.
    logic [9:0] mem_cnt_reg, mem_cnt_next; // Ticks spent off with memory.
    logic       count_latch_reg, count_latch_next;
    logic       delay_complete_latch_reg, delay_complete_latch_next;
    logic       mem_reg, mem_next;         // Short-outage memory.

    // The memory stands in for the charged capacitor: it is armed once
    // the delay completes and lapses after one second with the filament off.
    always_comb begin
        fil_on                    = din.filament_on_input;
        div_next                  = div_reg;
        reheat_next               = reheat_reg;
        mem_cnt_next              = mem_cnt_reg;
        count_latch_next          = count_latch_reg;
        delay_complete_latch_next = delay_complete_latch_reg;
        mem_next                  = mem_reg;
        if (!fil_on) begin
            div_next                  = '0;
            reheat_next               = '0;
            count_latch_next          = 1'b0;
            delay_complete_latch_next = 1'b0;
            if (mem_reg && tick) begin
                if (mem_cnt_reg == OUTAGE_TICKS - 1'b1) begin
                    mem_next     = 1'b0;
                    mem_cnt_next = '0;
                end else begin
                    mem_cnt_next = mem_cnt_reg + 1'b1;
                end
            end
        end else begin
            mem_cnt_next = '0;
            if (!count_latch_reg) begin
                if (mem_reg) begin
                    count_latch_next = 1'b1;
                end else if (tick) begin
                    if (div_reg == FIL_TICKS - 1'b1) begin
                        count_latch_next = 1'b1;
                    end
                    div_next = div_reg + 1'b1;
                end
            end else if (!delay_complete_latch_reg && tick) begin
                if (reheat_reg == REHEAT_TICKS - 1'b1) begin
                    delay_complete_latch_next = 1'b1;
                end
                reheat_next = reheat_reg + 1'b1;
            end
            if (delay_complete_latch_reg) begin
                mem_next = 1'b1;
            end
        end
    end

    // *************************************************************
    // High-tension step-start delay.
    // *************************************************************
    logic          cont_on;              // Main contactor energised.
    logic [SW-1:0] step_reg, step_next;  // Clocks since contactor closed.
    logic          step_done;            // Delay elapsed.

    // The timer restarts from zero at every closure, limiting inrush.
    always_comb begin
        cont_on   = !din.main_contactor_input;
        step_done = (step_reg == STEP_LAST);
        step_next = step_reg;
        if (!cont_on) begin
            step_next = '0;
        end else if (!step_done) begin
            step_next = step_reg + 1'b1;
        end
    end

    // *************************************************************
    // Sequence gate chain.
    // *************************************************************
    ass_seq_e           state_reg, state_next; // Current step.
    logic [N_GATES-1:0] gate;                  // Gate conditions, in order.
    int                 depth;                 // Leading satisfied gates.

    // A gate counts only if all before it hold; the state climbs one
    // step per clock and falls straight back to the last good step.
    always_comb begin
        gate[0] = din.mains_on;
        gate[1] = din.supplies_normal_input;
        gate[2] = din.aux_select;
        gate[3] = din.fil_bias_aux_started;
        gate[4] = din.fil_supply_ok && din.bias_ok && din.aux_supply_ok
                  && delay_complete_latch_reg;
        gate[5] = din.ht_select && cont_on;
        gate[6] = din.screen_ok;
        gate[7] = din.tune_complete;
        depth = 0;
        for (int i = 0; i < N_GATES; i++) begin
            if (depth == i && gate[i]) begin
                depth = i + 1;
            end
        end
        if (depth > int'(state_reg)) begin
            state_next = ass_seq_e'(state_reg + 1'b1);
        end else begin
            state_next = ass_seq_e'(4'(depth));
        end
    end

    // *************************************************************
    // Output stage.
    // *************************************************************
    ass_out_s out_next; // Next value of the output group.

    // All outputs leave from flip-flops; each lags its cause by one clock.
    always_comb begin
        out_next.lamps              = lamp_bar(state_reg);
        out_next.fil_bias_start_cmd = (state_reg >= SEQ_AUX_START);
        out_next.ht_start_cmd       = (state_reg >= SEQ_AUX_COMPLETE);
        out_next.screen_start_cmd   = (state_reg >= SEQ_HT_START);
        out_next.filament_delay_complete_n = !delay_complete_latch_reg;
        out_next.filament_delay_indicator  = delay_complete_latch_reg;
        out_next.step_start_contactor_n    = !(cont_on && step_done);
    end

    // Registers of the timing, sequence and output groups.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tcnt_reg                 <= '0;
            div_reg                  <= '0;
            reheat_reg               <= '0;
            mem_cnt_reg              <= '0;
            count_latch_reg          <= 1'b0;
            delay_complete_latch_reg <= 1'b0;
            mem_reg                  <= 1'b0;
            step_reg                 <= '0;
            state_reg                <= SEQ_OFF;
            amp_out                  <= OUT_RESET;
        end else begin
            tcnt_reg                 <= tcnt_next;
            div_reg                  <= div_next;
            reheat_reg               <= reheat_next;
            mem_cnt_reg              <= mem_cnt_next;
            count_latch_reg          <= count_latch_next;
            delay_complete_latch_reg <= delay_complete_latch_next;
            mem_reg                  <= mem_next;
            step_reg                 <= step_next;
            state_reg                <= state_next;
            amp_out                  <= out_next;
        end
    end

    // *************************************************************
    // Assertions.
    // *************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Restoration with memory held: count latch sets without a count.
    sequence s_warm_restart;
        $rose(fil_on) && mem_reg;
    endsequence
    sequence s_latch_set;
        count_latch_reg && (div_reg == '0);
    endsequence

    a_short_reheat: assert property (s_warm_restart |=> s_latch_set)
        else $error("count latch not set at once after short outage");
    a_full_count: assert property ($rose(count_latch_reg) |->
        ($past(div_reg) == FIL_TICKS - 1'b1) || $past(mem_reg))
        else $error("count latch set at wrong tick");
    a_reheat_time: assert property ($rose(delay_complete_latch_reg) |->
        $past(reheat_reg) == REHEAT_TICKS - 1'b1 && count_latch_reg)
        else $error("delay complete at wrong reheat count");
    a_filament_off: assert property (!fil_on |=> !count_latch_reg
        && !delay_complete_latch_reg && div_reg == '0
        ##1 amp_out.filament_delay_complete_n)
        else $error("filament off did not clear the delay");
    a_latch_hold: assert property (delay_complete_latch_reg && fil_on
        |=> delay_complete_latch_reg && count_latch_reg)
        else $error("latches dropped while filament on");
    a_memory_lapse: assert property ($fell(mem_reg) |->
        $past(mem_cnt_reg) == OUTAGE_TICKS - 1'b1 && !$past(fil_on))
        else $error("outage memory lapsed at wrong time");
    a_step_release: assert property (!cont_on |=> amp_out.step_start_contactor_n
        && step_reg == '0)
        else $error("step-start not released");
    a_step_delay: assert property ($fell(amp_out.step_start_contactor_n) |->
        $past(step_reg) == STEP_LAST && $past(cont_on))
        else $error("step-start driven early");
    a_seq_order: assert property (state_reg > $past(state_reg) |->
        int'(state_reg) == int'($past(state_reg)) + 1)
        else $error("sequence skipped a gate");
    a_lamp_bar: assert property (##1 amp_out.lamps == lamp_bar($past(state_reg)))
        else $error("lamps do not match the step reached");
endmodule
`default_nettype wire

// [ass_amp_model.sv]
// Behavioural model of the amplifier supplies, contactors and filament feed.
`timescale 1ns/1ps
`default_nettype none
module ass_amp_model (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire ass_pkg::ass_out_s amp_out,
    input  wire logic              slow,
    input  wire logic              bias_fault,
    input  wire logic              fil_cut,
    input  wire logic              cont_pulse,
    output var  logic              started,
    output var  logic              supplies_ok,
    output var  logic              bias_ok,
    output var  logic              contactor_n,
    output var  logic              screen_ok,
    output var  logic              filament_on
);
    import ass_pkg::*;
    // *****************************************************************
    // Command histories.
    // *****************************************************************
    logic [31:0] fil_q;   // Supply start command history, newest in bit 0.
    logic [31:0] ht_q;    // High tension command history.
    logic [31:0] scr_q;   // Screen supply command history.
    logic [4:0]  tap;     // Response delay in clocks.

    // Each supply answers its command after a prompt or a slow delay.
    // Only change slow while the histories are steady, or outputs glitch.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fil_q <= '0;
            ht_q  <= '0;
            scr_q <= '0;
        end else begin
            fil_q <= {fil_q[30:0], amp_out.fil_bias_start_cmd};
            ht_q  <= {ht_q[30:0], amp_out.ht_start_cmd};
            scr_q <= {scr_q[30:0], amp_out.screen_start_cmd};
        end
    end

    // Faults and outages are forced by the bench on top of the delayed answers.
    assign tap         = slow ? 5'h1E : 5'h02;
    assign started     = fil_q[tap];
    assign supplies_ok = fil_q[tap];
    assign bias_ok     = fil_q[tap] & ~bias_fault;
    assign filament_on = fil_q[tap] & ~fil_cut;
    assign contactor_n = ~(ht_q[tap] | cont_pulse);
    assign screen_ok   = scr_q[tap];
endmodule
`default_nettype wire

// [amplifier_supply_sequencer_test.sv]
// Self-checking testbench for the amplifier supply sequencer.
`timescale 1ns/1ps
`default_nettype none
module amplifier_supply_sequencer_test;
    import ass_pkg::*;
    // *****************************************************************
    // Signals and short design counts.
    // *****************************************************************
    localparam int TICK = 10;  // Clocks per tick, short for simulation.
    localparam int STEP = 20;  // Step-start delay clocks.
    localparam int FILT = 3;   // Glitch filter length.
    logic        clk, resetn;                 // Clock and raw reset.
    ass_in_s     amp_in;                      // Inputs to the sequencer.
    ass_out_s    amp_out;                     // Outputs of the sequencer.
    logic        mains, sup_norm, aux_sel;    // Bench-owned status lines.
    logic        ht_sel, tune, slow;          // Selections and model speed.
    logic        bias_fault, fil_cut, cont_pulse; // Fault injections.
    logic        started, sup_ok, bias_ok, cont_n, scr_ok, fil_on; // Model lines.
    int          errors, compares;            // Result counters.
    logic [31:0] seed;                        // Random state.
    logic [1:0]  sel;                         // Which gate the random step drops.

    assign amp_in = {mains, sup_norm, aux_sel, started, sup_ok, bias_ok, sup_ok,
                     ht_sel, cont_n, scr_ok, tune, fil_on};

    ass_sequencer #(.TICK_CYC(TICK), .STEP_CYC(STEP), .FILT_CYC(FILT)) u_dut (
        .clk(clk), .resetn(resetn), .amp_in(amp_in), .amp_out(amp_out));

    ass_amp_model u_amp (.clk(clk), .resetn(resetn), .amp_out(amp_out), .slow(slow),
        .bias_fault(bias_fault), .fil_cut(fil_cut), .cont_pulse(cont_pulse),
        .started(started), .supplies_ok(sup_ok), .bias_ok(bias_ok),
        .contactor_n(cont_n), .screen_ok(scr_ok), .filament_on(fil_on));

    // *****************************************************************
    // Helpers.
    // *****************************************************************
    // Clock at 10 MHz.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Xorshift step for repeatable random values.
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction

    // Lamp bar expected when the first d gates are satisfied.
    function automatic logic [7:0] bar(input int d);
        return 8'((9'h001 << d) - 9'h001);
    endfunction

    // One comparison; a mismatch is reported at once.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Sampling happens on the falling edge, well clear of the driving edge.
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Wait, bounded, for the filament feed to come on.
    task automatic wait_rise();
        int n;
        n = 0;
        while (fil_on !== 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
    endtask

    // Count clocks until the delay complete line goes low; judge the span.
    task automatic wait_lo(input int lo, input int hi, input string what);
        int n;
        n = 0;
        while (amp_out.filament_delay_complete_n !== 1'b0 && n < hi + 20) begin
            cyc(1);
            n++;
        end
        check(what, 32'(n >= lo && n <= hi), 32'h1);
        check("delay lamp", 32'(amp_out.filament_delay_indicator), 32'h1);
    endtask

    // Wait, bounded, for the whole lamp bar to light.
    task automatic wait_full();
        int n;
        n = 0;
        while (amp_out.lamps !== 8'hFF && n < 400) begin
            cyc(1);
            n++;
        end
        check("lamps full", 32'(amp_out.lamps), 32'hFF);
    endtask

    // Counts, verdict and end of run.
    task automatic report_and_stop();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog sized at about twice the expected run.
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        report_and_stop();
    end

    // *****************************************************************
    // Main sequence.
    // *****************************************************************
    initial begin
        errors = 0;
        compares = 0;
        seed = 32'h36DAFB7F;
        resetn = 1'b0;
        {mains, sup_norm, aux_sel, ht_sel, tune} = '0;
        {slow, bias_fault, fil_cut, cont_pulse} = '0;
        cyc(2);
        check("reset outputs", 32'(amp_out), 32'(OUT_RESET));
        @(posedge clk) resetn <= 1'b1;
        cyc(5);
        // A pulse shorter than the filter must never start the step-start timer.
        @(posedge clk) cont_pulse <= 1'b1;
        @(posedge clk);
        @(posedge clk) cont_pulse <= 1'b0;
        cyc(STEP + 20);
        check("glitch ignored", 32'(amp_out.step_start_contactor_n), 32'h1);
        // Twice round, so the second pass proves the timer was cleared.
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) cont_pulse <= 1'b1;
            cyc(FILT + STEP - 2);
            check("step early", 32'(amp_out.step_start_contactor_n), 32'h1);
            cyc(15);
            check("step on", 32'(amp_out.step_start_contactor_n), 32'h0);
            @(posedge clk) cont_pulse <= 1'b0;
            cyc(FILT + 6);
            check("step released", 32'(amp_out.step_start_contactor_n), 32'h1);
        end
        // Run-up: supplies normal stays low through reset, then grants available.
        @(posedge clk) mains <= 1'b1;
        cyc(12);
        check("mains lamp", 32'(amp_out.lamps), 32'(bar(1)));
        @(posedge clk) sup_norm <= 1'b1;
        cyc(12);
        check("available lamp", 32'(amp_out.lamps), 32'(bar(2)));
        @(posedge clk) {aux_sel, ht_sel, tune} <= 3'b111;
        wait_rise();
        cyc(40);
        check("held for heat", 32'(amp_out.lamps), 32'(bar(4)));
        wait_lo(7940, 7980, "full delay");
        wait_full();
        cyc(STEP);
        check("step after run", 32'(amp_out.step_start_contactor_n), 32'h0);
        // Short outage: latches reset, then only the reheat span.
        @(posedge clk) fil_cut <= 1'b1;
        cyc(30);
        check("outage reset", 32'(amp_out.filament_delay_complete_n), 32'h1);
        check("outage lamps", 32'(amp_out.lamps), 32'(bar(4)));
        check("outage step", 32'(amp_out.step_start_contactor_n), 32'h1);
        cyc(30);
        @(posedge clk) fil_cut <= 1'b0;
        wait_rise();
        wait_lo(300, 345, "reheat span");
        // Long switch-off: memory lapses, so the full count runs again.
        @(posedge clk) fil_cut <= 1'b1;
        cyc(40 * TICK);
        check("off latch", 32'(amp_out.filament_delay_indicator), 32'h0);
        @(posedge clk) fil_cut <= 1'b0;
        wait_rise();
        wait_lo(7980, 8020, "long outage");
        wait_full();
        // Random drops of one gate at standby, with random model speed.
        for (int i = 0; i < 6; i++) begin
            cyc(40);
            seed = xs(seed);
            sel = 2'(seed[7:0] % 3);
            @(posedge clk) begin
                slow <= seed[9];
                tune <= (sel != 2'h0);
                ht_sel <= (sel != 2'h1);
                bias_fault <= (sel == 2'h2);
            end
            cyc(12 + int'(seed[12:10]));
            check("lamps to fault", 32'(amp_out.lamps),
                  32'(bar(sel == 2'h0 ? 7 : sel == 2'h1 ? 5 : 4)));
            @(posedge clk) {tune, ht_sel, bias_fault} <= 3'b110;
            wait_full();
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
